// ### pss_defs.svh
/*
  Constants of the pressure sensor serial readout: frame field lengths,
  instruction codes, the resynchronisation pattern, calibration contents
  and conversion timing.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// ----------------------------------------------------------------------
// Frame layout on the command line
// ----------------------------------------------------------------------
`define PSS_START_LAST 5'd2
`define PSS_SETUP_LAST 5'd3
`define PSS_STOP_LAST 5'd2
`define PSS_ACK_LAST 5'd1
`define PSS_READ_LAST 5'd16
`define PSS_RESULT_BITS 16

// ----------------------------------------------------------------------
// Setup codes and resynchronisation pattern, chosen for this design
// ----------------------------------------------------------------------
`define PSS_CODE_PRESSURE 4'ha
`define PSS_CODE_TEMPERATURE 4'h9
`define PSS_CODE_WORD1 4'h5
`define PSS_CODE_WORD2 4'h6
`define PSS_CODE_WORD3 4'hc
`define PSS_CODE_WORD4 4'h3
`define PSS_RESET_LEN 21
`define PSS_RESET_PATTERN 21'h155540

// ----------------------------------------------------------------------
// Factory calibration words (arbitrary values)
// ----------------------------------------------------------------------
`define PSS_CAL_WORD1 16'h1a2b
`define PSS_CAL_WORD2 16'h3c4d
`define PSS_CAL_WORD3 16'h5e6f
`define PSS_CAL_WORD4 16'h7081

// ----------------------------------------------------------------------
// Conversion timing in master clock periods
// ----------------------------------------------------------------------
`define PSS_CONV_MCLK_CYCLES 16'd1000

`endif

// ### pss_pkg.sv
/*
  Types shared by the pressure sensor serial readout modules.
  Assumes nothing of its surroundings.
*/
package pss_pkg;

  // Protocol states of the link side.
  typedef enum logic [2:0] {
    LK_HUNT,
    LK_SETUP,
    LK_STOP,
    LK_ACK,
    LK_WAIT,
    LK_READ
  } pss_link_state_t;

  // Decoded instruction.
  typedef enum logic [2:0] {
    SEL_PRESSURE,
    SEL_TEMPERATURE,
    SEL_WORD1,
    SEL_WORD2,
    SEL_WORD3,
    SEL_WORD4,
    SEL_NONE
  } pss_select_t;

endpackage

// ### pss_sync.sv
/*
  Two-stage level synchroniser of configurable width.
  Assumes each bit is a level that stays long enough to be seen.
*/
`timescale 1ns/1ps

module pss_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input wire logic clk,
  // Asynchronous levels and their synchronised copy.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end

endmodule

// ### pss_conv.sv
/*
  Conversion sequencer: times a conversion in master clock periods and
  captures the selected sample as the result.
  Assumes start is a one-cycle pulse and the kind input is stable at it.
*/
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_conv import pss_pkg::*; #(
  parameter logic [15:0] CONV_MCLK = `PSS_CONV_MCLK_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Master clock pin.
  input wire logic mclk,
  // Request.
  input wire logic start,
  input wire logic kind_temp,
  // Samples from the converter.
  input wire logic [15:0] pressure_sample,
  input wire logic [15:0] temperature_sample,
  // Status and result.
  output logic done,
  output logic [15:0] result
);

  logic mclk_s;
  logic mclk_prev_reg;
  logic busy_reg;
  logic kind_reg;
  logic [15:0] tick_reg;

  pss_sync #(.WIDTH(1)) u_mclk_sync (
    .clk(clock),
    .d(mclk),
    .q(mclk_s)
  );

  // Remembers the master clock level to find its rising edges.
  always_ff @(posedge clock) begin
    if (srst) begin
      mclk_prev_reg <= 1'b0;
    end else begin
      mclk_prev_reg <= mclk_s;
    end
  end

  // Runs a conversion for a fixed number of master clock periods.
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_reg <= 1'b0;
      done <= 1'b0;
      kind_reg <= 1'b0;
      tick_reg <= 16'h0000;
      result <= 16'h0000;
    end else if (start) begin
      busy_reg <= 1'b1;
      done <= 1'b0;
      kind_reg <= kind_temp;
      tick_reg <= 16'h0000;
    end else if (busy_reg && mclk_s && !mclk_prev_reg) begin
      if (tick_reg == CONV_MCLK - 16'h0001) begin
        busy_reg <= 1'b0;
        done <= 1'b1;
        result <= kind_reg ? temperature_sample : pressure_sample;
      end else begin
        tick_reg <= tick_reg + 16'h0001;
      end
    end
  end

endmodule

// ### pss_top.sv
/*
  Serial command and readout port of the pressure sensor module: frame
  decoder and result shifter on the serial clock, conversion sequencer
  and output pin driver on the system clock.
  Assumes the host drives sclk and din and never clocks while waiting
  for a conversion to end.
*/
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_top import pss_pkg::*; #(
  parameter logic [15:0] CONV_MCLK = `PSS_CONV_MCLK_CYCLES
) (
  // System clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Serial link pins.
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  // Master clock pin.
  input wire logic mclk,
  // Converter samples.
  input wire logic [15:0] pressure_sample,
  input wire logic [15:0] temperature_sample
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pss_link_state_t state_reg;
  pss_select_t sel_now;
  logic link_rst;
  logic [4:0] cnt_reg;
  logic [3:0] code_reg;
  logic [3:0] code_next;
  logic [15:0] shift_reg;
  logic [20:0] hist_reg;
  logic [20:0] hist_next;
  logic reset_hit;
  logic link_dout_reg;
  logic link_wait_reg;
  logic start_tgl_reg;
  logic kind_temp_reg;
  logic [2:0] link_s;
  logic tgl_seen_reg;
  logic conv_start;
  logic conv_done;
  logic [15:0] conv_result;
  logic dout_reg;

  // Maps a setup code to an instruction.
  function automatic pss_select_t decode_setup(input logic [3:0] code);
    case (code)
      `PSS_CODE_PRESSURE: decode_setup = SEL_PRESSURE;
      `PSS_CODE_TEMPERATURE: decode_setup = SEL_TEMPERATURE;
      `PSS_CODE_WORD1: decode_setup = SEL_WORD1;
      `PSS_CODE_WORD2: decode_setup = SEL_WORD2;
      `PSS_CODE_WORD3: decode_setup = SEL_WORD3;
      `PSS_CODE_WORD4: decode_setup = SEL_WORD4;
      default: decode_setup = SEL_NONE;
    endcase
  endfunction

  // Selects the calibration word for a readout instruction.
  function automatic logic [15:0] cal_word(input pss_select_t sel);
    case (sel)
      SEL_WORD1: cal_word = `PSS_CAL_WORD1;
      SEL_WORD2: cal_word = `PSS_CAL_WORD2;
      SEL_WORD3: cal_word = `PSS_CAL_WORD3;
      default: cal_word = `PSS_CAL_WORD4;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Link domain: reset, pattern watch and frame decoder
  // ----------------------------------------------------------------------

  // Brings the system reset into the serial clock domain.
  pss_sync #(.WIDTH(1)) u_rst_sync (
    .clk(sclk),
    .d(srst),
    .q(link_rst)
  );

  // The last 21 command bits, including the one now sampled.
  assign hist_next = {hist_reg[19:0], din};
  assign reset_hit = (hist_next == `PSS_RESET_PATTERN);
  assign code_next = {code_reg[2:0], din};
  assign sel_now = decode_setup(code_reg);

  // Keeps the command history; it shifts in every protocol state.
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      hist_reg <= 21'h000000;
    end else begin
      hist_reg <= hist_next;
    end
  end

  // Frame decoder and output shifter, all on the rising serial clock.
  always_ff @(posedge sclk) begin
    if (link_rst || reset_hit) begin
      state_reg <= LK_HUNT;
      cnt_reg <= 5'd0;
      code_reg <= 4'h0;
      shift_reg <= 16'h0000;
      link_dout_reg <= 1'b0;
      link_wait_reg <= 1'b0;
    end else begin
      case (state_reg)
        LK_HUNT: begin
          if (!din) begin
            cnt_reg <= 5'd0;
          end else if (cnt_reg == `PSS_START_LAST) begin
            state_reg <= LK_SETUP;
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        LK_SETUP: begin
          code_reg <= code_next;
          if (cnt_reg == `PSS_SETUP_LAST) begin
            state_reg <= LK_STOP;
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        LK_STOP: begin
          if (din) begin
            state_reg <= LK_HUNT;
            cnt_reg <= 5'd0;
          end else if (cnt_reg != `PSS_STOP_LAST) begin
            cnt_reg <= cnt_reg + 5'd1;
          end else if (sel_now == SEL_PRESSURE || sel_now == SEL_TEMPERATURE) begin
            state_reg <= LK_ACK;
            cnt_reg <= 5'd0;
            link_dout_reg <= 1'b1;
          end else if (sel_now == SEL_NONE) begin
            state_reg <= LK_HUNT;
            cnt_reg <= 5'd0;
          end else begin
            state_reg <= LK_READ;
            cnt_reg <= 5'd0;
            shift_reg <= cal_word(sel_now);
          end
        end
        LK_ACK: begin
          if (cnt_reg == `PSS_ACK_LAST) begin
            state_reg <= LK_WAIT;
            link_wait_reg <= 1'b1;
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        LK_WAIT: begin
          // First readout clock; the result has been stable since done.
          state_reg <= LK_READ;
          link_wait_reg <= 1'b0;
          link_dout_reg <= conv_result[15];
          shift_reg <= {conv_result[14:0], 1'b0};
          cnt_reg <= 5'd1;
        end
        LK_READ: begin
          // A held clock simply freezes this count and the shifter.
          if (cnt_reg == `PSS_READ_LAST) begin
            state_reg <= LK_HUNT;
            link_dout_reg <= 1'b0;
            cnt_reg <= 5'd0;
          end else begin
            link_dout_reg <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        default: begin
          state_reg <= LK_HUNT;
          cnt_reg <= 5'd0;
        end
      endcase
    end
  end

  // Launches a conversion by toggling; the kind stays put until the next one.
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      start_tgl_reg <= 1'b0;
      kind_temp_reg <= 1'b0;
    end else if (!reset_hit && state_reg == LK_STOP && !din && cnt_reg == `PSS_STOP_LAST
                 && (sel_now == SEL_PRESSURE || sel_now == SEL_TEMPERATURE)) begin
      start_tgl_reg <= !start_tgl_reg;
      kind_temp_reg <= (sel_now == SEL_TEMPERATURE);
    end
  end

  // ----------------------------------------------------------------------
  // System domain: conversion and output pin
  // ----------------------------------------------------------------------

  // Carries the start toggle, wait level and output bit into this domain.
  pss_sync #(.WIDTH(3)) u_link_sync (
    .clk(clock),
    .d({start_tgl_reg, link_wait_reg, link_dout_reg}),
    .q(link_s)
  );

  // Turns each toggle into a one-cycle start pulse.
  always_ff @(posedge clock) begin
    if (srst) begin
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= link_s[2];
    end
  end
  assign conv_start = link_s[2] ^ tgl_seen_reg;

  pss_conv #(.CONV_MCLK(CONV_MCLK)) u_conv (
    .clock(clock),
    .srst(srst),
    .mclk(mclk),
    .start(conv_start),
    .kind_temp(kind_temp_reg),
    .pressure_sample(pressure_sample),
    .temperature_sample(temperature_sample),
    .done(conv_done),
    .result(conv_result)
  );

  // Drives the pin: pulled low at end of conversion while waiting.
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_reg <= 1'b0;
    end else if (link_s[1] && conv_done) begin
      dout_reg <= 1'b0;
    end else begin
      dout_reg <= link_s[0];
    end
  end
  assign dout = dout_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_last_stop_conv;
    state_reg == LK_STOP && cnt_reg == `PSS_STOP_LAST && !din && !reset_hit
      && (sel_now == SEL_PRESSURE || sel_now == SEL_TEMPERATURE);
  endsequence

  // The acknowledge stands through both extra clocks; the wait phase is seen after the second.
  sequence s_ack_then_wait;
    state_reg == LK_ACK && link_dout_reg ##1 state_reg == LK_ACK && link_dout_reg
      ##1 state_reg == LK_WAIT && link_wait_reg;
  endsequence

  property p_start_frame;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_HUNT && din && cnt_reg == `PSS_START_LAST && !reset_hit)
        |=> state_reg == LK_SETUP && cnt_reg == 5'd0;
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("start bits not accepted");

  property p_setup_capture;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_SETUP && !reset_hit) |=> code_reg[0] == $past(din);
  endproperty
  a_setup_capture: assert property (p_setup_capture) else $error("setup bit lost");

  property p_setup_len;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_SETUP && cnt_reg == `PSS_SETUP_LAST && !reset_hit)
        |=> state_reg == LK_STOP;
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup field length wrong");

  property p_ack;
    @(posedge sclk) disable iff (link_rst)
      s_last_stop_conv |=> s_ack_then_wait;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge sequence wrong");

  property p_word_read;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_STOP && cnt_reg == `PSS_STOP_LAST && !din && !reset_hit
       && sel_now inside {SEL_WORD1, SEL_WORD2, SEL_WORD3, SEL_WORD4})
        |=> state_reg == LK_READ && shift_reg == cal_word($past(sel_now));
  endproperty
  a_word_read: assert property (p_word_read) else $error("calibration word not loaded");

  property p_read_bit;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_READ && cnt_reg != `PSS_READ_LAST && !reset_hit)
        |=> link_dout_reg == $past(shift_reg[15]);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("readout bit wrong");

  property p_read_end;
    @(posedge sclk) disable iff (link_rst)
      (state_reg == LK_READ && cnt_reg == `PSS_READ_LAST && !reset_hit)
        |=> state_reg == LK_HUNT && !link_dout_reg;
  endproperty
  a_read_end: assert property (p_read_end) else $error("readout length wrong");

  property p_reset_pattern;
    @(posedge sclk) disable iff (link_rst)
      reset_hit |=> state_reg == LK_HUNT && cnt_reg == 5'd0 && !link_wait_reg;
  endproperty
  a_reset_pattern: assert property (p_reset_pattern) else $error("reset pattern ignored");

  property p_done_low;
    @(posedge clock) disable iff (srst)
      (link_s[1] && conv_done) |=> !dout_reg;
  endproperty
  a_done_low: assert property (p_done_low) else $error("end of conversion not shown");

endmodule

// ### pss_host.sv
/*
  Host model for the serial readout link: makes the serial clock, sends
  framed commands and the resynchronisation pattern, and reads words back.
  Assumes dout settles well within half a serial clock period of a rise.
*/
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_host (
  // Link pins.
  output logic sclk,
  output logic din,
  input wire logic dout
);
  // ------------------------------------------------------------
  // Serial clock and bit transfer
  // ------------------------------------------------------------
  localparam int HALF = 80;
  localparam logic [20:0] PAT = `PSS_RESET_PATTERN;

  // The clock stands low between transfers; only the tasks pulse it.
  initial begin
    sclk = 1'b0;
    din = 1'b0;
  end

  // One pulse: din changes while sclk is low, dout is read at the fall.
  task automatic xfer(input logic b, output logic s);
    din = b;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
    s = dout;
  endtask

  // Sends one framed instruction; s is dout after the last stop bit.
  task automatic frame(input logic [3:0] code, output logic s);
    logic [9:0] f;
    f = {3'b111, code, 3'b000};
    for (int i = 9; i >= 0; i--) begin
      xfer(f[i], s);
    end
  endtask

  // Sends the resynchronisation pattern; dout may toggle, so it is ignored.
  task automatic resync();
    logic s;
    for (int i = `PSS_RESET_LEN - 1; i >= 0; i--) begin
      xfer(PAT[i], s);
    end
  endtask

  // Gives 17 clocks and collects the word; the clock may be held mid-word.
  task automatic read17(input int pause_ns, output logic [15:0] w, output logic last);
    logic s;
    for (int k = 1; k <= 17; k++) begin
      if (k == 9) #(pause_ns);
      xfer(1'b0, s);
      if (k <= 16) w[16 - k] = s;
      else last = s;
    end
  endtask

  // Holds the clock low and watches for the end-of-conversion fall.
  task automatic wait_low(input int limit_ns, output logic fell);
    fell = 1'b0;
    for (int t = 0; t < limit_ns && !fell; t += 40) begin
      #40;
      fell = (dout === 1'b0);
    end
  endtask
endmodule

// ### pss_top_bench.sv
/*
  Self-checking bench of the serial readout port, driven by the host model.
  Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/1ps
`include "pss_defs.svh"

module pss_top_bench;
  // ------------------------------------------------------------
  // Clocks, design and host
  // ------------------------------------------------------------
  localparam logic [15:0] CONV = 16'h0004;
  localparam int MCLK_HALF = 1907;
  localparam int MCLK_NS = 2 * MCLK_HALF * 8;
  localparam int LIMIT = 80000;

  logic clock, srst, mclk, sclk, din, dout, s0;
  logic [15:0] pressure_sample, temperature_sample;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int mcnt = 0;

  pss_top #(.CONV_MCLK(CONV)) u_pss_top (
    .clock(clock), .srst(srst), .sclk(sclk), .din(din), .dout(dout), .mclk(mclk),
    .pressure_sample(pressure_sample), .temperature_sample(temperature_sample)
  );

  pss_host u_pss_host (.sclk(sclk), .din(din), .dout(dout));

  // System clock of 8 ns.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  // Master clock near 32.768 kHz and the hang limit.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (mcnt == MCLK_HALF - 1) begin
      mcnt <= 0;
      mclk <= #1 ~mclk;
    end else begin
      mcnt <= mcnt + 1;
    end
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reads all four calibration words once, one of them with a pause.
  task automatic cal_words();
    logic [3:0] codes [4] = '{`PSS_CODE_WORD1, `PSS_CODE_WORD2, `PSS_CODE_WORD3,
                              `PSS_CODE_WORD4};
    logic [15:0] words [4] = '{`PSS_CAL_WORD1, `PSS_CAL_WORD2, `PSS_CAL_WORD3,
                               `PSS_CAL_WORD4};
    logic [15:0] w;
    logic s, last;
    for (int i = 0; i < 4; i++) begin
      u_pss_host.frame(codes[i], s);
      check({15'h0000, s}, 16'h0000);
      u_pss_host.read17(i == 2 ? 3000 : 0, w, last);
      check(w, words[i]);
      check({15'h0000, last}, 16'h0000);
    end
  endtask

  // An unknown code and a broken stop field leave the output low.
  task automatic refused();
    logic [9:0] bad = 10'h3aa;
    logic [15:0] w;
    logic s, last;
    u_pss_host.frame(4'h0, s);
    check({15'h0000, s}, 16'h0000);
    u_pss_host.read17(0, w, last);
    check(w, 16'h0000);
    for (int i = 9; i >= 0; i--) begin
      u_pss_host.xfer(bad[i], s);
    end
    check({15'h0000, s}, 16'h0000);
    u_pss_host.read17(0, w, last);
    check(w, 16'h0000);
  endtask

  // One conversion: acknowledge, busy level, end fall and result.
  task automatic convert(input logic [3:0] code, input logic [15:0] exp, input int pause_ns);
    logic [15:0] w;
    logic s, fell;
    u_pss_host.frame(code, s);
    check({15'h0000, s}, 16'h0001);
    repeat (2) begin
      u_pss_host.xfer(1'b0, s);
      check({15'h0000, s}, 16'h0001);
    end
    #(2 * MCLK_NS);
    check({15'h0000, dout}, 16'h0001);
    u_pss_host.wait_low(8 * MCLK_NS, fell);
    check({15'h0000, fell}, 16'h0001);
    u_pss_host.read17(pause_ns, w, s);
    check(w, exp);
    check({15'h0000, s}, 16'h0000);
  endtask

  // Resynchronises while a conversion waits, then reads a word at once.
  task automatic resync_mid();
    logic [15:0] w;
    logic s, last;
    u_pss_host.frame(`PSS_CODE_PRESSURE, s);
    u_pss_host.resync();
    u_pss_host.frame(`PSS_CODE_WORD2, s);
    check({15'h0000, s}, 16'h0000);
    u_pss_host.read17(0, w, last);
    check(w, `PSS_CAL_WORD2);
  endtask

  // Main sequence; the serial clock must run while reset is held.
  initial begin
    srst = 1'b1;
    mclk = 1'b0;
    pressure_sample = 16'h8c31;
    temperature_sample = 16'h47e5;
    #37;
    repeat (4) u_pss_host.xfer(1'b0, s0);
    @(posedge clock);
    #1 srst = 1'b0;
    repeat (4) u_pss_host.xfer(1'b0, s0);
    u_pss_host.resync();
    cal_words();
    refused();
    convert(`PSS_CODE_PRESSURE, 16'h8c31, 0);
    convert(`PSS_CODE_TEMPERATURE, 16'h47e5, 2500);
    resync_mid();
    wrap_up();
  end
endmodule
